//--- acb_pkg.sv
// Constants shared by the converter configuration register bank.
package acb_pkg;

	// ------------------------------------------------------------------
	// Register addresses and widths
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 16;
	localparam int          TRIM_W        = 3;
	localparam logic [3:0]  ADDR_MAIN_CFG = 4'h0;
	localparam logic [3:0]  ADDR_CM_TRIM  = 4'h1;

	// ------------------------------------------------------------------
	// Power-on reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] MAIN_CFG_RST  = 16'h2000;
	localparam logic [15:0] CM_TRIM_RST   = 16'h2A00;
	localparam logic [15:0] READ_IDLE     = 16'h0000;
	localparam logic [2:0]  TRIM_DEFAULT  = 3'h0;

	// ------------------------------------------------------------------
	// Main configuration field positions
	// ------------------------------------------------------------------
	localparam int CAL_BIT        = 15;
	localparam int DDR_PHASE_BIT  = 14;
	localparam int SWING_BIT      = 13;
	localparam int PATTERN_BIT    = 12;
	localparam int SLEEP1_BIT     = 11;
	localparam int SLEEP2_BIT     = 10;
	localparam int RSVD_HI_BIT    = 9;
	localparam int SLOW_CLK_BIT   = 8;
	localparam int INTERLEAVE_BIT = 7;
	localparam int PICK_BIT       = 6;
	localparam int TIED_BIT       = 5;
	localparam int SIGNED_BIT     = 4;
	localparam int RSVD_LO_MSB    = 3;
	localparam int RSVD_LO_LSB    = 0;

	// ------------------------------------------------------------------
	// Common-mode register field positions
	// ------------------------------------------------------------------
	localparam int TRIM_MSB       = 7;
	localparam int TRIM_LSB       = 5;

endpackage

//--- acb_reg16.sv
// One 16-bit configuration register with a power-on value.
`timescale 1ns/100ps
module acb_reg16
	import acb_pkg::*;
#(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Write port.
	input  wire logic        we_i,
	input  wire logic [15:0] wdata_i,
	// Stored word.
	output logic      [15:0] value_o
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------

	// The word keeps its power-on value until software writes it.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			value_o <= RESET_VALUE;
		end else if (we_i) begin
			value_o <= wdata_i;
		end
	end

endmodule // acb_reg16

//--- acb_cal_trig.sv
// Calibration request combiner and start pulse generator.
`timescale 1ns/100ps
module acb_cal_trig (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Request sources.
	input  wire logic reg_req_i,
	input  wire logic pin_req_i,
	// Start pulse and combined level.
	output logic      cal_start_o,
	output logic      cal_level_o
);

	// ------------------------------------------------------------------
	// Request combining
	// ------------------------------------------------------------------

	// Either source asks; a new start needs the OR to have been low first.
	wire logic req_any;
	wire logic req_rise;

	assign req_any  = reg_req_i | pin_req_i;
	assign req_rise = req_any & ~cal_level_o;

	// Holding a source high never retriggers, so the bit is not self-clearing.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_level_o <= 1'b0;
			cal_start_o <= 1'b0;
		end else begin
			cal_level_o <= req_any;
			cal_start_o <= req_rise;
		end
	end

endmodule // acb_cal_trig

//--- acb_config_bank.sv
// Configuration register bank of a dual-channel high-speed converter.
`timescale 1ns/100ps
module acb_config_bank
	import acb_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	// Control mode and output arrangement.
	input  wire logic        extended_register_control_i,
	input  wire logic        demux_mode_i,
	// Decoded serial control port access.
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	output logic      [15:0] rdata_o,
	output logic             rvalid_o,
	// Dedicated pins, always honoured.
	input  wire logic        cal_pin_i,
	input  wire logic        first_sleep_pin_i,
	input  wire logic        second_sleep_pin_i,
	// Pin settings used outside extended control mode.
	input  wire logic        pin_ddr_phase_i,
	input  wire logic        pin_swing_high_i,
	input  wire logic        pin_fixed_pattern_i,
	input  wire logic        pin_interleave_i,
	input  wire logic        pin_interleave_pick_i,
	// Calibration control.
	output logic             cal_start_o,
	output logic             cal_request_o,
	// Output stage settings.
	output logic             ddr_phase_choice_o,
	output logic             output_swing_high_o,
	output logic             fixed_pattern_output_o,
	output logic             signed_output_format_o,
	output logic [2:0]       output_common_mode_trim_o,
	// Channel and sampling settings.
	output logic             first_channel_sleep_o,
	output logic             second_channel_sleep_o,
	output logic             slow_sample_clock_select_o,
	output logic             interleave_enable_o,
	output logic             interleave_input_pick_o,
	output logic             interleave_inputs_tied_o,
	output logic             interleave_second_input_mode_o,
	output logic             interleave_tied_input_mode_o
);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------

	// Assertion is immediate; release is retimed so no flop sees a runt.
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------

	// One decoder serves both the write strobes and the read mux.
	function automatic logic addr_hit(input logic [3:0] a,
	                                  input logic [3:0] target);
		addr_hit = (a == target);
	endfunction

	wire logic        sel_main;
	wire logic        sel_trim;
	wire logic        we_main;
	wire logic        we_trim;
	wire logic [15:0] main_cfg;
	wire logic [15:0] cm_trim;

	assign sel_main = addr_hit(addr_i, ADDR_MAIN_CFG);
	assign sel_trim = addr_hit(addr_i, ADDR_CM_TRIM);
	assign we_main  = wr_i & sel_main;
	assign we_trim  = wr_i & sel_trim;

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------

	// Reserved bits are stored as written; software keeps them legal.
	acb_reg16 #(
		.RESET_VALUE (MAIN_CFG_RST)
	) u_main_cfg (
		.clk_i   (mclk_i),
		.rst_b_i (rst_sync_q),
		.we_i    (we_main),
		.wdata_i (wdata_i),
		.value_o (main_cfg)
	);

	acb_reg16 #(
		.RESET_VALUE (CM_TRIM_RST)
	) u_cm_trim (
		.clk_i   (mclk_i),
		.rst_b_i (rst_sync_q),
		.we_i    (we_trim),
		.wdata_i (wdata_i),
		.value_o (cm_trim)
	);

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------

	// Unmapped addresses read as zero rather than aliasing a register.
	wire logic [15:0] rdata_d;

	assign rdata_d = sel_main ? main_cfg :
	                 sel_trim ? cm_trim  : READ_IDLE;

	// Read data is registered so it stays stable for the shift-out.
	always_ff @(posedge mclk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rdata_o  <= READ_IDLE;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd_i;
			if (rd_i) begin
				rdata_o <= rdata_d;
			end
		end
	end

	// ------------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------------

	// Raw register fields, before the control mode selects a source.
	wire logic       reg_cal;
	wire logic       reg_phase;
	wire logic       reg_swing;
	wire logic       reg_pattern;
	wire logic       reg_sleep1;
	wire logic       reg_sleep2;
	wire logic       reg_slow_clk;
	wire logic       reg_interleave;
	wire logic       reg_pick;
	wire logic       reg_tied;
	wire logic       reg_signed;
	wire logic [2:0] reg_trim;

	assign reg_cal        = main_cfg[CAL_BIT];
	assign reg_phase      = main_cfg[DDR_PHASE_BIT];
	assign reg_swing      = main_cfg[SWING_BIT];
	assign reg_pattern    = main_cfg[PATTERN_BIT];
	assign reg_sleep1     = main_cfg[SLEEP1_BIT];
	assign reg_sleep2     = main_cfg[SLEEP2_BIT];
	assign reg_slow_clk   = main_cfg[SLOW_CLK_BIT];
	assign reg_interleave = main_cfg[INTERLEAVE_BIT];
	assign reg_pick       = main_cfg[PICK_BIT];
	assign reg_tied       = main_cfg[TIED_BIT];
	assign reg_signed     = main_cfg[SIGNED_BIT];
	assign reg_trim       = cm_trim[TRIM_MSB:TRIM_LSB];

	// ------------------------------------------------------------------
	// Source selection by control mode
	// ------------------------------------------------------------------

	// Outside extended mode the pins or fixed defaults decide and register fields are dead.
	wire logic       extended_register_control;
	wire logic       cal_reg_req;
	wire logic       eff_phase_sel;
	wire logic       eff_swing;
	wire logic       eff_pattern;
	wire logic       eff_interleave;
	wire logic       eff_pick_sel;
	wire logic       eff_tied_sel;
	wire logic       eff_signed;
	wire logic       eff_slow_clk;
	wire logic [2:0] eff_trim;

	assign extended_register_control            = extended_register_control_i;
	assign cal_reg_req    = extended_register_control & reg_cal;
	assign eff_phase_sel  = extended_register_control ? reg_phase : pin_ddr_phase_i;
	assign eff_swing      = extended_register_control ? reg_swing : pin_swing_high_i;
	assign eff_pattern    = extended_register_control ? reg_pattern : pin_fixed_pattern_i;
	assign eff_interleave = extended_register_control ? reg_interleave : pin_interleave_i;
	assign eff_pick_sel   = extended_register_control ? reg_pick : pin_interleave_pick_i;
	assign eff_tied_sel   = extended_register_control & reg_tied;
	assign eff_signed     = extended_register_control & reg_signed;
	assign eff_slow_clk   = extended_register_control & reg_slow_clk;
	assign eff_trim       = extended_register_control ? reg_trim : TRIM_DEFAULT;

	// ------------------------------------------------------------------
	// Derived modes
	// ------------------------------------------------------------------

	// Phase only matters for demuxed outputs; hold 0 degrees otherwise.
	wire logic phase_d;
	wire logic pick_d;
	wire logic tied_d;
	wire logic sleep1_d;
	wire logic sleep2_d;
	wire logic second_mode_d;
	wire logic tied_mode_d;

	assign phase_d  = demux_mode_i & eff_phase_sel;
	assign pick_d   = eff_interleave & eff_pick_sel;
	assign tied_d   = eff_interleave & eff_tied_sel;
	assign sleep1_d = (extended_register_control & reg_sleep1) | first_sleep_pin_i;
	assign sleep2_d = (extended_register_control & reg_sleep2) | second_sleep_pin_i;

	// Named mode flags; the tied flag expects the 101b pattern.
	assign second_mode_d = eff_interleave & pick_d & ~tied_d;
	assign tied_mode_d   = eff_interleave & ~pick_d & tied_d;

	// ------------------------------------------------------------------
	// Calibration request
	// ------------------------------------------------------------------

	// Register bit and pin merge into one start pulse.
	wire logic cal_start;
	wire logic cal_level;

	acb_cal_trig u_cal_trig (
		.clk_i       (mclk_i),
		.rst_b_i     (rst_sync_q),
		.reg_req_i   (cal_reg_req),
		.pin_req_i   (cal_pin_i),
		.cal_start_o (cal_start),
		.cal_level_o (cal_level)
	);

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------

	// Every output comes from a flop; settings act one edge after a write.
	always_ff @(posedge mclk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cal_start_o                    <= 1'b0;
			cal_request_o                  <= 1'b0;
			ddr_phase_choice_o             <= 1'b0;
			output_swing_high_o            <= 1'b1;
			fixed_pattern_output_o         <= 1'b0;
			signed_output_format_o         <= 1'b0;
			output_common_mode_trim_o      <= TRIM_DEFAULT;
			first_channel_sleep_o          <= 1'b0;
			second_channel_sleep_o         <= 1'b0;
			slow_sample_clock_select_o     <= 1'b0;
			interleave_enable_o            <= 1'b0;
			interleave_input_pick_o        <= 1'b0;
			interleave_inputs_tied_o       <= 1'b0;
			interleave_second_input_mode_o <= 1'b0;
			interleave_tied_input_mode_o   <= 1'b0;
		end else begin
			cal_start_o                    <= cal_start;
			cal_request_o                  <= cal_level;
			ddr_phase_choice_o             <= phase_d;
			output_swing_high_o            <= eff_swing;
			fixed_pattern_output_o         <= eff_pattern;
			signed_output_format_o         <= eff_signed;
			output_common_mode_trim_o      <= eff_trim;
			first_channel_sleep_o          <= sleep1_d;
			second_channel_sleep_o         <= sleep2_d;
			slow_sample_clock_select_o     <= eff_slow_clk;
			interleave_enable_o            <= eff_interleave;
			interleave_input_pick_o        <= pick_d;
			interleave_inputs_tied_o       <= tied_d;
			interleave_second_input_mode_o <= second_mode_d;
			interleave_tied_input_mode_o   <= tied_mode_d;
		end
	end

endmodule // acb_config_bank

//--- acb_config_bank_asserts.sv
// Port-level checks for the converter configuration register bank.
`timescale 1ns/100ps
module acb_config_bank_asserts
	import acb_pkg::*;
(
	// Clock and reset.
	input wire logic        mclk_i,
	input wire logic        rst_b_i,
	// Control inputs.
	input wire logic        extended_register_control_i,
	input wire logic        demux_mode_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        cal_pin_i,
	input wire logic        first_sleep_pin_i,
	// Outputs watched.
	input wire logic [15:0] rdata_o,
	input wire logic        rvalid_o,
	input wire logic        cal_start_o,
	input wire logic        cal_request_o,
	input wire logic        ddr_phase_choice_o,
	input wire logic        signed_output_format_o,
	input wire logic [2:0]  output_common_mode_trim_o,
	input wire logic        first_channel_sleep_o,
	input wire logic        interleave_enable_o,
	input wire logic        interleave_input_pick_o,
	input wire logic        interleave_inputs_tied_o,
	input wire logic        interleave_tied_input_mode_o
);
	// ------------------------------------------------------------
	// Settling window
	// ------------------------------------------------------------
	// Checks wait three edges after release, matching the internal
	// two-flop reset plus the first legal request edge.
	logic [2:0] up_q;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			up_q <= 3'h0;
		else
			up_q <= {up_q[1:0], 1'b1};
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!up_q[2]);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_rd_answer: assert property (rd_i |=> rvalid_o)
		else $error("read strobe got no valid pulse");
	chk_no_stray_valid: assert property (!rd_i |=> !rvalid_o)
		else $error("valid pulse without a read");
	chk_trim_readback: assert property (
		wr_i && addr_i == ADDR_CM_TRIM ##1 !wr_i ##1
		rd_i && !wr_i && addr_i == ADDR_CM_TRIM
		|=> rdata_o == $past(wdata_i, 3))
		else $error("trim word not read back as written");
	chk_unmapped_zero: assert property (
		rd_i && addr_i > ADDR_CM_TRIM |=> rdata_o == READ_IDLE)
		else $error("unmapped read not zero");
	chk_cal_one_pulse: assert property (
		cal_start_o == $rose(cal_request_o))
		else $error("start pulse not tied to request rise");
	chk_cal_pin_path: assert property (
		cal_pin_i |-> ##2 cal_request_o)
		else $error("calibration pin did not raise request");
	chk_sleep_pin: assert property (
		first_sleep_pin_i [*3] |-> first_channel_sleep_o)
		else $error("sleep pin ignored");
	chk_phase_no_demux: assert property (
		!demux_mode_i [*3] |-> !ddr_phase_choice_o)
		else $error("phase set without demux");
	chk_plain_mode: assert property (
		!extended_register_control_i [*3] |->
		output_common_mode_trim_o == TRIM_DEFAULT && !signed_output_format_o)
		else $error("register setting leaked outside extended mode");
	chk_tied_mode: assert property (
		interleave_tied_input_mode_o |-> interleave_enable_o &&
		interleave_inputs_tied_o && !interleave_input_pick_o)
		else $error("tied input mode without its pattern");

	// Main scenarios reached.
	cover property (cal_start_o);
	cover property (interleave_tied_input_mode_o);
	cover property (rvalid_o && rdata_o == CM_TRIM_RST);
endmodule // acb_config_bank_asserts

bind acb_config_bank acb_config_bank_asserts u_acb_config_bank_asserts (.*);

//--- acb_host_model.sv
// Host model driving the decoded control port of the register bank.
`timescale 1ns/100ps
module acb_host_model
	import acb_pkg::*;
(
	// Clock.
	input  wire logic        clk_i,
	// Requests toward the bank.
	output logic             wr_o,
	output logic             rd_o,
	output logic [3:0]       addr_o,
	output logic [15:0]      wdata_o,
	// Answer from the bank.
	input  wire logic [15:0] rdata_i,
	input  wire logic        rvalid_i
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 4'h0;
		wdata_o = 16'h0000;
	end

	// Idle lines carry the inverse of the last value, so a bank that
	// samples them outside a strobe sees garbage, not a stale word.
	task automatic write(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a == ADDR_MAIN_CFG)
			v = v & 16'hFDF0;
		if (a == ADDR_CM_TRIM)
			v = {CM_TRIM_RST[15:8], v[7:5], 5'h00};
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~v;
	endtask

	// The poll is bounded so a silent bank cannot hang the run.
	task automatic read(input logic [3:0] a, output logic [15:0] d,
		output logic ok);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		ok = 1'b0;
		d = 16'h0000;
		// Look just after each edge, where the answer has settled.
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (rvalid_i === 1'b1) begin
				ok = 1'b1;
				d = rdata_i;
			end else begin
				@(posedge clk_i);
			end
		end
	endtask
endmodule // acb_host_model

//--- acb_config_bank_tb_top.sv
// Self-checking testbench for the configuration register bank.
`timescale 1ns/100ps
module acb_config_bank_tb_top
	import acb_pkg::*;
;
	localparam logic [15:0] SET_MASK = 16'h7D90;
	logic        mclk_i, rst_b_i, extended_register_control_i;
	logic        demux_mode_i, cal_pin_i;
	logic        first_sleep_pin_i, second_sleep_pin_i;
	logic        pin_ddr_phase_i, pin_swing_high_i, pin_fixed_pattern_i;
	logic        pin_interleave_i, pin_interleave_pick_i;
	logic        wr_i, rd_i, rvalid_o, cal_start_o, cal_request_o;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i, rdata_o, rd_v;
	logic        ddr_phase_choice_o, output_swing_high_o;
	logic        fixed_pattern_output_o, signed_output_format_o;
	logic [2:0]  output_common_mode_trim_o;
	logic        first_channel_sleep_o, second_channel_sleep_o;
	logic        slow_sample_clock_select_o, interleave_enable_o;
	logic        interleave_input_pick_o, interleave_inputs_tied_o;
	logic        interleave_second_input_mode_o;
	logic        interleave_tied_input_mode_o, rd_ok;
	int          n_fail, n_checks, c;

	acb_config_bank u_acb_config_bank (.*);
	acb_host_model u_acb_host_model (.clk_i(mclk_i), .wr_o(wr_i),
		.rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i),
		.rdata_i(rdata_o), .rvalid_i(rvalid_o));

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string w, input logic [15:0] s,
		input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		u_acb_host_model.write(a, d);
	endtask
	task automatic rd_chk(input string w, input logic [3:0] a,
		input logic [15:0] e);
		u_acb_host_model.read(a, rd_v, rd_ok);
		if (!rd_ok) begin
			n_fail++;
			end_of_test();
		end
		check(w, rd_v, e);
	endtask
	// Outputs move one edge after a write; three leaves margin.
	task automatic settle();
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	task automatic starts();
		c = 0;
		repeat (5) begin
			@(posedge mclk_i);
			#1;
			if (cal_start_o === 1'b1)
				c++;
		end
	endtask
	function automatic logic [15:0] obs();
		return {1'b0, ddr_phase_choice_o, output_swing_high_o,
			fixed_pattern_output_o, first_channel_sleep_o,
			second_channel_sleep_o, 1'b0, slow_sample_clock_select_o,
			interleave_enable_o, 2'h0, signed_output_format_o, 4'h0};
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check("reset outputs", obs(), MAIN_CFG_RST & SET_MASK);
		wr(4'h2, 16'hFFFF);
		rd_chk("main reset", ADDR_MAIN_CFG, MAIN_CFG_RST);
		rd_chk("trim reset", ADDR_CM_TRIM, CM_TRIM_RST);
		rd_chk("unmapped 5", 4'h5, READ_IDLE);
		rd_chk("unmapped F", 4'hF, READ_IDLE);
	endtask
	task automatic t_fields();
		for (int b = 4; b < 15; b++) begin
			if (SET_MASK[b]) begin
				wr(ADDR_MAIN_CFG, 16'h0001 << b);
				settle();
				check("one field", obs(), 16'h0001 << b);
			end
		end
		wr(ADDR_MAIN_CFG, SET_MASK);
		settle();
		check("all fields", obs(), SET_MASK);
		rd_chk("main back", ADDR_MAIN_CFG, SET_MASK);
	endtask
	task automatic t_modes();
		logic [2:0] p;
		for (int i = 0; i < 8; i++) begin
			p = 3'(i);
			wr(ADDR_MAIN_CFG, {8'h00, p, 5'h00});
			settle();
			check("mode", {11'h0, interleave_enable_o,
				interleave_input_pick_o, interleave_inputs_tied_o,
				interleave_second_input_mode_o,
				interleave_tied_input_mode_o}, {11'h0, p[2], p[2] & p[1],
				p[2] & p[0], p == 3'h6, p == 3'h5});
		end
	endtask
	task automatic t_trim();
		logic [2:0] t;
		for (int i = 7; i >= 0; i--) begin
			t = 3'(i);
			wr(ADDR_CM_TRIM, {8'h2A, t, 5'h00});
			rd_chk("trim back", ADDR_CM_TRIM, {8'h2A, t, 5'h00});
			settle();
			check("trim", {13'h0, output_common_mode_trim_o}, {13'h0, t});
		end
	endtask
	task automatic t_cal();
		wr(ADDR_MAIN_CFG, 16'h8000);
		starts();
		check("cal start", 16'(c), 16'h0001);
		check("cal level", {15'h0, cal_request_o}, 16'h0001);
		wr(ADDR_MAIN_CFG, 16'h8000);
		starts();
		check("cal held", 16'(c), 16'h0000);
		@(posedge mclk_i);
		cal_pin_i <= 1'b1;
		starts();
		check("pin while bit", 16'(c), 16'h0000);
		@(posedge mclk_i);
		cal_pin_i <= 1'b0;
		wr(ADDR_MAIN_CFG, 16'h0000);
		wr(ADDR_MAIN_CFG, 16'h8000);
		starts();
		check("cal again", 16'(c), 16'h0001);
		wr(ADDR_MAIN_CFG, 16'h0000);
		settle();
		@(posedge mclk_i);
		cal_pin_i <= 1'b1;
		starts();
		check("pin start", 16'(c), 16'h0001);
		@(posedge mclk_i);
		cal_pin_i <= 1'b0;
	endtask
	task automatic t_pins();
		@(posedge mclk_i);
		first_sleep_pin_i <= 1'b1;
		second_sleep_pin_i <= 1'b1;
		demux_mode_i <= 1'b0;
		wr(ADDR_MAIN_CFG, 16'h4000);
		settle();
		check("pins", obs(), 16'h0C00);
		@(posedge mclk_i);
		first_sleep_pin_i <= 1'b0;
		second_sleep_pin_i <= 1'b0;
		demux_mode_i <= 1'b1;
	endtask
	task automatic t_plain();
		@(posedge mclk_i);
		extended_register_control_i <= 1'b0;
		pin_fixed_pattern_i <= 1'b1;
		pin_interleave_i <= 1'b1;
		pin_ddr_phase_i <= 1'b1;
		pin_swing_high_i <= 1'b1;
		pin_interleave_pick_i <= 1'b1;
		wr(ADDR_MAIN_CFG, 16'h9190);
		wr(ADDR_CM_TRIM, 16'h2AE0);
		settle();
		check("plain", obs(), 16'h7080);
		check("plain trim", {11'h0, interleave_input_pick_o, cal_request_o,
			output_common_mode_trim_o}, 16'h0010);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_b_i = 1'b0;
		extended_register_control_i = 1'b1;
		demux_mode_i = 1'b1;
		{cal_pin_i, first_sleep_pin_i, second_sleep_pin_i} = 3'h0;
		{pin_ddr_phase_i, pin_swing_high_i, pin_fixed_pattern_i} = 3'h0;
		{pin_interleave_i, pin_interleave_pick_i} = 2'h0;
		repeat (5) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		settle();
		t_reset();
		t_fields();
		t_modes();
		t_trim();
		t_cal();
		t_pins();
		t_plain();
		end_of_test();
	end
endmodule // acb_config_bank_tb_top
